// ==== twmc_top.v ====
// Timer/counter waveform generator with two compare channels and its
// Avalon-MM register slave.
// Assumes the timer tick and the port direction bits come from logic on clk.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`include "twmc_regs.vh"

module twmc_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Avalon-MM slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Timer tick and port direction
    input  wire        timerTick,
    input  wire        dirOutA,
    input  wire        dirOutB,
    // Compare outputs
    output wire        compareOutA,
    output wire        compareOutAEn,
    output wire        overrideA,
    output wire        compareOutB,
    output wire        compareOutBEn,
    output wire        overrideB,
    // Status
    output reg  [2:0]  matchFlags
);

    // Mode classes
    localparam CLS_NONE  = 3'b000;
    localparam CLS_NPWM  = 3'b001;
    localparam CLS_FAST  = 3'b010;
    localparam CLS_DUAL  = 3'b100;

    // Bus handshake states
    localparam BUS_IDLE  = 2'b01;
    localparam BUS_ACK   = 2'b10;

    // Registers
    reg  [7:0]  ctrlA_q;
    reg  [1:0]  ctrlB_q;
    reg  [15:0] count_q;
    reg  [15:0] cmpA_q;
    reg  [15:0] cmpABuf_q;
    reg  [15:0] cmpB_q;
    reg  [15:0] cmpBBuf_q;
    reg  [15:0] capture_q;
    reg         countDown_q;
    reg         blockMatch_q;
    reg  [1:0]  busState_q;
    reg  [1:0]  forceNow_q;

    // Decoded mode and counter conditions
    wire [3:0]  waveformModeSel;
    wire [2:0]  modeCls;
    wire [15:0] topValue;
    wire        atTop;
    wire        atBottom;
    wire        updAtTop;
    wire        updAtBottom;
    wire        immUpdate;
    wire        ovfEv;
    wire        loadEv;
    wire        wrapEv;
    wire        matchA;
    wire        matchB;
    wire        toggleA;
    wire        busDone;
    wire        wrAcc;
    wire        rdAcc;
    reg  [15:0] count_d;
    reg         countDown_d;
    reg  [31:0] readData_d;

    // Class of a mode: non-PWM, fast single slope, dual slope, or none for reserved mode 13
    function [2:0] modeClass;
        input [3:0] m;
        begin
            case (m)
                4'h0, 4'h4, 4'hC:                      modeClass = CLS_NPWM;
                4'h5, 4'h6, 4'h7, 4'hE, 4'hF:          modeClass = CLS_FAST;
                4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: modeClass = CLS_DUAL;
                default:                               modeClass = CLS_NONE;
            endcase
        end
    endfunction

    // TOP value of a mode
    function [15:0] modeTop;
        input [3:0]  m;
        input [15:0] regA;
        input [15:0] regCap;
        begin
            case (m)
                4'h1, 4'h5:             modeTop = `TWMC_TOP_8BIT;
                4'h2, 4'h6:             modeTop = `TWMC_TOP_9BIT;
                4'h3, 4'h7:             modeTop = `TWMC_TOP_10BIT;
                4'h4, 4'h9, 4'hB, 4'hF: modeTop = regA;
                4'h8, 4'hA, 4'hC, 4'hE: modeTop = regCap;
                default:                modeTop = `TWMC_TOP_MAX;
            endcase
        end
    endfunction

    // Byte-lane merge of a 16-bit register
    function [15:0] laneMerge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  be;
        begin
            laneMerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    // Mode is two low bits of control A and two bits of control B
    assign waveformModeSel = {ctrlB_q, ctrlA_q[`TWMC_WMODE_LOW_HI:`TWMC_WMODE_LOW_LO]};
    assign modeCls  = modeClass(waveformModeSel);
    assign topValue = modeTop(waveformModeSel, cmpA_q, capture_q);
    assign atTop    = (count_q >= topValue);
    assign atBottom = (count_q == `TWMC_BOTTOM);

    // Update points of the compare buffers
    assign immUpdate   = modeCls[0];
    assign updAtTop    = (waveformModeSel == 4'h1) || (waveformModeSel == 4'h2) ||
                         (waveformModeSel == 4'h3) || (waveformModeSel == 4'hA) ||
                         (waveformModeSel == 4'hB);
    assign updAtBottom = modeCls[1] || (waveformModeSel == 4'h8) || (waveformModeSel == 4'h9);

    // Counter events, all qualified by the tick
    assign wrapEv = timerTick && (modeCls[0] || modeCls[1]) && atTop;
    assign ovfEv  = timerTick && (
                        (modeCls[0] && (count_q == `TWMC_TOP_MAX)) ||
                        (modeCls[1] && atTop) ||
                        (modeCls[2] && countDown_q && atBottom));
    assign loadEv = timerTick && (
                        (updAtTop && !countDown_q && atTop) ||
                        (updAtBottom && modeCls[1] && atTop) ||
                        (updAtBottom && modeCls[2] && countDown_q && atBottom));
    assign matchA = timerTick && !blockMatch_q && (count_q == cmpA_q);
    assign matchB = timerTick && !blockMatch_q && (count_q == cmpB_q);
    assign toggleA = (waveformModeSel == 4'hF) ||
                     (waveformModeSel == 4'h9);

    // Bus access strobes: writes act at the edge where waitrequest is sampled low, reads capture data one edge earlier
    assign busDone = (busState_q == BUS_ACK);
    assign wrAcc   = avs_write && busDone;
    assign rdAcc   = avs_read && !busDone;

    // Next count value and direction
    always @* begin
        count_d     = count_q;
        countDown_d = countDown_q;
        if (timerTick) begin
            if (modeCls[2]) begin
                if (!countDown_q && atTop) begin
                    countDown_d = 1'b1;
                    count_d     = count_q - 16'h0001;
                end else if (countDown_q && atBottom) begin
                    countDown_d = 1'b0;
                    count_d     = count_q + 16'h0001;
                end else if (countDown_q) begin
                    count_d = count_q - 16'h0001;
                end else begin
                    count_d = count_q + 16'h0001;
                end
            end else if (wrapEv) begin
                countDown_d = 1'b0;
                count_d     = `TWMC_BOTTOM;
            end else if (modeCls != CLS_NONE) begin
                countDown_d = 1'b0;
                count_d     = count_q + 16'h0001;
            end
        end
    end

    // Read mux, strobe bits always zero
    always @* begin
        readData_d = 32'h0000_0000;
        case (avs_address)
            `TWMC_OFS_CTRL_A:  readData_d[7:0] = {ctrlA_q[7:4], 2'b00, ctrlA_q[1:0]};
            `TWMC_OFS_CTRL_B:  readData_d[`TWMC_WMODE_HIGH_HI:`TWMC_WMODE_HIGH_LO] = ctrlB_q;
            `TWMC_OFS_COUNT:   readData_d[15:0] = count_q;
            `TWMC_OFS_CMP_A:   readData_d[15:0] = cmpABuf_q;
            `TWMC_OFS_CMP_B:   readData_d[15:0] = cmpBBuf_q;
            `TWMC_OFS_CAPTURE: readData_d[15:0] = capture_q;
            `TWMC_OFS_FLAGS:   readData_d[2:0]  = matchFlags;
            default:           readData_d = 32'h0000_0000;
        endcase
    end

    // Bus handshake: one wait cycle, then waitrequest low for one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busState_q      <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        busState_q      <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    busState_q      <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    busState_q      <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
            if (rdAcc)
                avs_readdata <= readData_d;
        end
    end

    // Control registers and force strobes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlA_q    <= `TWMC_RST_CTRL_A;
            ctrlB_q    <= `TWMC_RST_CTRL_B;
            forceNow_q <= 2'b00;
        end else begin
            forceNow_q <= 2'b00;
            if (wrAcc && avs_byteenable[0] && (avs_address == `TWMC_OFS_CTRL_A)) begin
                ctrlA_q <= {avs_writedata[7:4], 2'b00, avs_writedata[1:0]};
                // Strobes act only in non-PWM modes, judged by the mode being written
                if (modeClass({ctrlB_q, avs_writedata[1:0]}) == CLS_NPWM)
                    forceNow_q <= {avs_writedata[`TWMC_FORCE_A], avs_writedata[`TWMC_FORCE_B]};
            end
            if (wrAcc && avs_byteenable[0] && (avs_address == `TWMC_OFS_CTRL_B))
                ctrlB_q <= avs_writedata[`TWMC_WMODE_HIGH_HI:`TWMC_WMODE_HIGH_LO];
        end
    end

    // Counter, direction and match blocking after a software count write
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q      <= `TWMC_RST_WORD;
            countDown_q  <= 1'b0;
            blockMatch_q <= 1'b0;
        end else begin
            if (wrAcc && (avs_address == `TWMC_OFS_COUNT)) begin
                count_q      <= laneMerge(count_q, avs_writedata, avs_byteenable);
                blockMatch_q <= 1'b1;
            end else begin
                count_q     <= count_d;
                countDown_q <= countDown_d;
                if (timerTick)
                    blockMatch_q <= 1'b0;
            end
        end
    end

    // Compare buffers and active compare values, capture register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmpA_q    <= `TWMC_RST_WORD;
            cmpABuf_q <= `TWMC_RST_WORD;
            cmpB_q    <= `TWMC_RST_WORD;
            cmpBBuf_q <= `TWMC_RST_WORD;
            capture_q <= `TWMC_RST_WORD;
        end else begin
            if (wrAcc && (avs_address == `TWMC_OFS_CMP_A)) begin
                cmpABuf_q <= laneMerge(cmpABuf_q, avs_writedata, avs_byteenable);
                if (immUpdate)
                    cmpA_q <= laneMerge(cmpABuf_q, avs_writedata, avs_byteenable);
            end else if (loadEv || immUpdate) begin
                cmpA_q <= cmpABuf_q;
            end
            if (wrAcc && (avs_address == `TWMC_OFS_CMP_B)) begin
                cmpBBuf_q <= laneMerge(cmpBBuf_q, avs_writedata, avs_byteenable);
                if (immUpdate)
                    cmpB_q <= laneMerge(cmpBBuf_q, avs_writedata, avs_byteenable);
            end else if (loadEv || immUpdate) begin
                cmpB_q <= cmpBBuf_q;
            end
            if (wrAcc && (avs_address == `TWMC_OFS_CAPTURE))
                capture_q <= laneMerge(capture_q, avs_writedata, avs_byteenable);
        end
    end

    // Sticky flags: write one to clear, a new event wins over the clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            matchFlags <= 3'b000;
        end else begin
            if (wrAcc && avs_byteenable[0] && (avs_address == `TWMC_OFS_FLAGS))
                matchFlags <= (matchFlags & ~avs_writedata[2:0]) |
                              {matchB, matchA, ovfEv};
            else
                matchFlags <= matchFlags | {matchB, matchA, ovfEv};
        end
    end

    // Channel A, toggle allowed in modes 9 and 15 (mode 14 is fast PWM)
    twmc_chan uChanA (
        .clk         (clk),
        .rst_n       (rst_n),
        .tick        (timerTick),
        .matchEv     (matchA),
        .bottomEv    (wrapEv),
        .countUp     (!countDown_q),
        .nonPwm      (modeCls[0]),
        .fastPwm     (modeCls[1]),
        .dualPwm     (modeCls[2]),
        .toggleOk    (toggleA),
        .cmpIsTop    (cmpA_q == topValue),
        .cmpIsZero   (cmpA_q == `TWMC_BOTTOM),
        .outMode     (ctrlA_q[`TWMC_OMODE_A_HI:`TWMC_OMODE_A_LO]),
        .forceStrobe (forceNow_q[1]),
        .dirOut      (dirOutA),
        .pinLevel_q  (compareOutA),
        .pinEnable_q (compareOutAEn),
        .override_q  (overrideA)
    );

    // Channel B, toggle never allowed in PWM modes
    twmc_chan uChanB (
        .clk         (clk),
        .rst_n       (rst_n),
        .tick        (timerTick),
        .matchEv     (matchB),
        .bottomEv    (wrapEv),
        .countUp     (!countDown_q),
        .nonPwm      (modeCls[0]),
        .fastPwm     (modeCls[1]),
        .dualPwm     (modeCls[2]),
        .toggleOk    (1'b0),
        .cmpIsTop    (cmpB_q == topValue),
        .cmpIsZero   (cmpB_q == `TWMC_BOTTOM),
        .outMode     (ctrlA_q[`TWMC_OMODE_B_HI:`TWMC_OMODE_B_LO]),
        .forceStrobe (forceNow_q[0]),
        .dirOut      (dirOutB),
        .pinLevel_q  (compareOutB),
        .pinEnable_q (compareOutBEn),
        .override_q  (overrideB)
    );

endmodule // twmc_top

// ==== twmc_regs.vh ====
// Register map, field positions, reset values and fixed TOP values of the
// 16-bit timer waveform and compare-output control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.
// Functional notes
// - Single clock; tick is only an enable
// - Frequency-correct mode: load and overflow at BOTTOM
// - Nonzero output mode takes the pin, toggle code only where allowed
// - Pin driven only when direction is output
// - Non-PWM codes: off, toggle, clear, set
// - Fast PWM: 10 non-inverting, 11 inverting
// - Fast PWM toggle only on A, mode 15
// - Fast PWM: match at TOP ignored by codes 10 and 11
// - Dual slope: 10 clear up, set down
// - Dual slope toggle on A, mode 9 only
// - Force strobes ignored in PWM modes
// - Force strobe applies match action at once
// - Force sets no flag, clears no counter
// - Force strobe bits always read zero
// - Mode is four bits over two registers
// - Normal and clear-on-match modes, overflow at MAX
// - Phase-correct modes: load TOP, overflow BOTTOM
// - Fast PWM: load BOTTOM, overflow at TOP
// - Frequency-correct modes 8 and 9
// - Dual slope: BOTTOM or TOP compare holds level for codes 10 and 11
// - Dual slope counts up, turns at TOP, down
`ifndef TWMC_REGS_VH
`define TWMC_REGS_VH

// Byte offsets
`define TWMC_OFS_CTRL_A     8'h00
`define TWMC_OFS_CTRL_B     8'h04
`define TWMC_OFS_COUNT      8'h08
`define TWMC_OFS_CMP_A      8'h0C
`define TWMC_OFS_CMP_B      8'h10
`define TWMC_OFS_CAPTURE    8'h14
`define TWMC_OFS_FLAGS      8'h18

// Control A fields
`define TWMC_OMODE_A_HI     7
`define TWMC_OMODE_A_LO     6
`define TWMC_OMODE_B_HI     5
`define TWMC_OMODE_B_LO     4
`define TWMC_FORCE_A        3
`define TWMC_FORCE_B        2
`define TWMC_WMODE_LOW_HI   1
`define TWMC_WMODE_LOW_LO   0
// Control B fields
`define TWMC_WMODE_HIGH_HI  4
`define TWMC_WMODE_HIGH_LO  3
// Flag fields
`define TWMC_FLAG_OVF       0
`define TWMC_FLAG_MATCH_A   1
`define TWMC_FLAG_MATCH_B   2

// Reset values
`define TWMC_RST_CTRL_A     8'h00
`define TWMC_RST_CTRL_B     2'h0
`define TWMC_RST_WORD       16'h0000

// Fixed TOP values
`define TWMC_TOP_MAX        16'hFFFF
`define TWMC_TOP_8BIT       16'h00FF
`define TWMC_TOP_9BIT       16'h01FF
`define TWMC_TOP_10BIT      16'h03FF
`define TWMC_BOTTOM         16'h0000

`endif

// ==== twmc_chan.v ====
// One compare-output channel: the output level and the pin override.
// Assumes events from the counter arrive on the same clock, already
// qualified by the timer tick.
module twmc_chan (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Counter events
    input  wire       tick,
    input  wire       matchEv,
    input  wire       bottomEv,
    input  wire       countUp,
    // Mode class
    input  wire       nonPwm,
    input  wire       fastPwm,
    input  wire       dualPwm,
    input  wire       toggleOk,
    input  wire       cmpIsTop,
    input  wire       cmpIsZero,
    // Control
    input  wire [1:0] outMode,
    input  wire       forceStrobe,
    input  wire       dirOut,
    // Pin side
    output reg        pinLevel_q,
    output reg        pinEnable_q,
    output reg        override_q
);

    wire connected;
    reg  pinLevel_d;

    // Toggle code only connects where allowed in PWM modes
    assign connected = (outMode == 2'b01) ? (nonPwm | toggleOk) : (outMode != 2'b00);

    // Next output level
    always @* begin
        pinLevel_d = pinLevel_q;
        if (nonPwm) begin
            if (forceStrobe || (tick && matchEv)) begin
                case (outMode)
                    2'b01:   pinLevel_d = ~pinLevel_q;
                    2'b10:   pinLevel_d = 1'b0;
                    2'b11:   pinLevel_d = 1'b1;
                    default: pinLevel_d = pinLevel_q;
                endcase
            end
        end else if (fastPwm && tick) begin
            if (outMode[1]) begin
                if (bottomEv)
                    pinLevel_d = ~outMode[0];
                else if (matchEv && !cmpIsTop)
                    pinLevel_d = outMode[0];
            end else if (outMode[0] && toggleOk && matchEv) begin
                pinLevel_d = ~pinLevel_q;
            end
        end else if (dualPwm && tick) begin
            if (outMode[1]) begin
                if (cmpIsZero)
                    pinLevel_d = outMode[0];
                else if (cmpIsTop)
                    pinLevel_d = ~outMode[0];
                else if (matchEv)
                    pinLevel_d = countUp ? outMode[0] : ~outMode[0];
            end else if (outMode[0] && toggleOk && matchEv) begin
                pinLevel_d = ~pinLevel_q;
            end
        end
    end

    // Output level, override and driver enable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinLevel_q  <= 1'b0;
            pinEnable_q <= 1'b0;
            override_q  <= 1'b0;
        end else begin
            pinLevel_q  <= pinLevel_d;
            override_q  <= connected;
            pinEnable_q <= connected & dirOut;
        end
    end

endmodule // twmc_chan

// ==== twmc_top_properties.sv ====
// Concurrent checks on the ports of the timer waveform block.
// Assumes it is bound into twmc_top and sees only that module's ports.
`include "twmc_regs.vh"

module twmc_top_properties (
    // Clock and reset
    input logic        clk,
    input logic        rst_n,
    // Register bus
    input logic [7:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    // Timer side
    input logic        timerTick,
    input logic        dirOutA,
    input logic        dirOutB,
    input logic        compareOutAEn,
    input logic        compareOutBEn,
    input logic [2:0]  matchFlags
);
    // One clock domain, quiet while reset is low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Bus answer comes after exactly one wait cycle and lasts one cycle
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped with no request");
    a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    // Read data content at the answer edge
    a_force_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == `TWMC_OFS_CTRL_A
        |-> avs_readdata[`TWMC_FORCE_A:`TWMC_FORCE_B] == 2'h0 && avs_readdata[31:8] == 24'h0)
        else $error("force strobe bits read nonzero");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > `TWMC_OFS_FLAGS |-> avs_readdata == 32'h0)
        else $error("unmapped address read nonzero");
    // Flags rise only after a tick and fall only after a bus write
    a_flag_tick: assert property (
        (matchFlags & ~$past(matchFlags)) != 3'h0 |-> $past(timerTick))
        else $error("flag set without a timer tick");
    a_flag_clear: assert property (
        ($past(matchFlags) & ~matchFlags) != 3'h0 |-> $past(avs_write && !avs_waitrequest))
        else $error("flag cleared without a write");
    // Pin drivers stay off while the direction bit is input
    a_drive_dir_a: assert property (!$past(dirOutA) |-> !compareOutAEn)
        else $error("pin A driven while direction is input");
    a_drive_dir_b: assert property (!$past(dirOutB) |-> !compareOutBEn)
        else $error("pin B driven while direction is input");
endmodule // twmc_top_properties

bind twmc_top twmc_top_properties u_twmc_top_properties (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timerTick(timerTick), .dirOutA(dirOutA), .dirOutB(dirOutB),
    .compareOutAEn(compareOutAEn), .compareOutBEn(compareOutBEn), .matchFlags(matchFlags));

// ==== twmc_tb_top.sv ====
// Self-checking bench for the timer waveform block.
// Assumes the Avalon-MM slave answers after one wait cycle.
`include "twmc_regs.vh"

module twmc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        timerTick = 1'b0;
    logic        dirOutA = 1'b1;
    logic        dirOutB = 1'b1;
    logic        compareOutA, compareOutAEn, overrideA;
    logic        compareOutB, compareOutBEn, overrideB;
    logic [2:0]  matchFlags;
    int          failures = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [31:0] r;

    twmc_top u_twmc_top (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timerTick(timerTick), .dirOutA(dirOutA), .dirOutB(dirOutB),
        .compareOutA(compareOutA), .compareOutAEn(compareOutAEn), .overrideA(overrideA),
        .compareOutB(compareOutB), .compareOutBEn(compareOutBEn), .overrideB(overrideB),
        .matchFlags(matchFlags));

    // Clock and hang guard
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            $display("Error at %0t: timeout", $time);
            results();
        end
    end

    task results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e, input string s);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, s, g, e);
        end
    endtask

    // Bus cycle: hold request until waitrequest is sampled low
    task bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask

    // Program a mode, run the timer and count high cycles of output A
    task run_row(input logic [3:0] m, input logic [1:0] c, input logic [15:0] ocr,
                 input logic [15:0] cap, input int n, input int ex, input logic ovf);
        int hi;
        timerTick <= 1'b0;
        wr(`TWMC_OFS_CMP_A, {16'h0, ocr});
        wr(`TWMC_OFS_CAPTURE, {16'h0, cap});
        wr(`TWMC_OFS_CTRL_B, {27'h0, m[3:2], 3'h0});
        wr(`TWMC_OFS_CTRL_A, {24'h0, c, 2'h1, 2'h0, m[1:0]});
        wr(`TWMC_OFS_COUNT, 32'h0);
        timerTick <= 1'b1;
        repeat (600) @(posedge clk);
        wr(`TWMC_OFS_FLAGS, 32'h7);
        repeat (600) @(posedge clk);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            hi += (compareOutA === 1'b1);
        end
        chk(32'(hi), 32'(ex), "high cycles");
        chk(32'(matchFlags[0]), 32'(ovf), "overflow flag");
        chk(32'(matchFlags[2:1]), 32'h3, "match flags");
        chk(32'(overrideB), 32'(m == 4 || m == 12), "toggle B connection");
    endtask

    // Main sequence
    initial begin
        logic [1:0] fc [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
        logic       fe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wr(8'h1C, 32'hFFFF);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'(i * 4), 32'h0);
            chk(r, 32'h0, "reset or unmapped read");
        end
        for (int i = 0; i < 4; i++) begin
            wr(`TWMC_OFS_CTRL_A, {24'h0, fc[i], 2'h0, 2'h2, 2'h0});
            repeat (3) @(posedge clk);
            chk(32'(compareOutA), 32'(fe[i]), "forced output A");
            chk(32'(compareOutAEn), 32'h1, "driver A");
        end
        chk(32'(matchFlags), 32'h0, "flags after force");
        bus(1'b1, `TWMC_OFS_CTRL_A, 32'h0);
        chk(r, 32'h40, "control A readback");
        dirOutA <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(compareOutAEn), 32'h0, "driver A with input direction");
        dirOutA <= 1'b1;
        wr(`TWMC_OFS_CTRL_A, 32'h34);
        repeat (3) @(posedge clk);
        chk(32'(overrideA), 32'h0, "output A disconnected");
        chk(32'(compareOutB), 32'h1, "forced output B");
        chk(32'(compareOutBEn), 32'h1, "driver B");
        dirOutB <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(compareOutBEn), 32'h0, "driver B with input direction");
        dirOutB <= 1'b1;
        wr(`TWMC_OFS_CTRL_B, 32'h18);
        wr(`TWMC_OFS_CTRL_A, 32'hCA);
        repeat (3) @(posedge clk);
        chk(32'(compareOutA), 32'h0, "force in PWM mode");
        wr(`TWMC_OFS_CTRL_A, 32'h42);
        repeat (3) @(posedge clk);
        chk(32'(overrideA), 32'h0, "toggle A in mode 14");
        wr(`TWMC_OFS_CTRL_A, 32'h41);
        timerTick <= 1'b1;
        repeat (20) @(posedge clk);
        bus(1'b1, `TWMC_OFS_COUNT, 32'h0);
        chk(r, 32'h0, "reserved mode count");
        chk(32'(overrideA), 32'h0, "reserved mode output");
        run_row(4'd5, 2'h2, 16'h0010, 16'h0, 1024, 68, 1'b1);
        run_row(4'd5, 2'h3, 16'h0010, 16'h0, 1024, 956, 1'b1);
        run_row(4'd5, 2'h2, 16'h00FF, 16'h0, 1024, 1024, 1'b1);
        run_row(4'd1, 2'h2, 16'h0040, 16'h0, 2040, 512, 1'b1);
        run_row(4'd1, 2'h3, 16'h0040, 16'h0, 2040, 1528, 1'b1);
        run_row(4'd1, 2'h2, 16'h0000, 16'h0, 2040, 0, 1'b1);
        run_row(4'd1, 2'h2, 16'h00FF, 16'h0, 2040, 2040, 1'b1);
        run_row(4'd8, 2'h2, 16'h0020, 16'h0063, 792, 256, 1'b1);
        run_row(4'd9, 2'h1, 16'h0031, 16'h0, 784, 392, 1'b1);
        run_row(4'd15, 2'h1, 16'h0031, 16'h0, 400, 200, 1'b1);
        run_row(4'd4, 2'h1, 16'h0031, 16'h0, 400, 200, 1'b0);
        run_row(4'd12, 2'h1, 16'h0010, 16'h0031, 400, 200, 1'b0);
        results();
    end
endmodule // twmc_tb_top
